// >>> pkg/rta_pkg.sv
// constants, state type and compare function for the rx termination and address matcher
package rta_pkg;

    // ========================================================================
    // register offsets (byte addresses)
    localparam int unsigned OFS_W            = 8;
    localparam logic [7:0]  OFS_TERM_CHARS   = 8'h34;
    localparam logic [7:0]  OFS_TERM_MASK    = 8'h38;
    localparam logic [7:0]  OFS_RX_ADDR      = 8'h3C;
    localparam logic [7:0]  OFS_RX_ADDR_MASK = 8'h40;
    localparam logic [7:0]  OFS_INT_STATUS   = 8'h80;
    localparam logic [7:0]  OFS_INT_MASK     = 8'h84;
    localparam logic [7:0]  OFS_FRAME_STATUS = 8'h88;

    // ========================================================================
    // reset values
    localparam logic [31:0] TERM_CHARS_RST   = 32'h0000_0000;
    localparam logic [31:0] TERM_MASK_RST    = 32'h0000_0000;
    localparam logic [31:0] RX_ADDR_RST      = 32'h0000_0000;
    localparam logic [31:0] RX_ADDR_MASK_RST = 32'h0000_0000;
    localparam logic [2:0]  INT_RST          = 3'h0;

    // ========================================================================
    // field layout
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned N_TERM     = 4;
    localparam int unsigned ADDR_W     = 16;
    localparam int unsigned STA_LSB    = 16;
    localparam int unsigned GRP_LSB    = 0;
    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_START  = 0;
    localparam int unsigned IRQ_END    = 1;
    localparam int unsigned IRQ_REJECT = 2;
    localparam logic [7:0]  HDLC_FLAG  = 8'h7E;

    // receive frame states, one-hot
    typedef enum logic [3:0] {
        RTA_HUNT    = 4'b0001,
        RTA_ADDR_HI = 4'b0010,
        RTA_ADDR_LO = 4'b0100,
        RTA_DATA    = 4'b1000
    } rta_state_t;

    // masked byte compare: a mask bit of one makes that position match
    function automatic logic rta_byte_eq(input logic [7:0] rx,
                                         input logic [7:0] exp,
                                         input logic [7:0] mask);
        return &(~(rx ^ exp) | mask);
    endfunction

endpackage

// >>> pkg/rta_match_if.sv
// interface between the frame controller and its two comparators
`timescale 1ns/100ps

interface rta_match_if;
    logic [31:0] window;
    logic [31:0] term_chars;
    logic [31:0] term_mask;
    logic [1:0]  term_count;
    logic        hdlc;
    logic        term_hit;
    logic [15:0] rx_addr;
    logic [31:0] addr_regs;
    logic [31:0] addr_mask;
    logic        wide;
    logic        addr_hit;

    modport ctrl (output window, term_chars, term_mask, term_count, hdlc,
                  output rx_addr, addr_regs, addr_mask, wide,
                  input  term_hit, addr_hit);
    modport term (input window, term_chars, term_mask, term_count, hdlc,
                  output term_hit);
    modport addr (input rx_addr, addr_regs, addr_mask, wide,
                  output addr_hit);
endinterface

// >>> hw/rta_term_match.sv
// termination sequence comparator over the last four received bytes
`timescale 1ns/100ps

module rta_term_match (
    rta_match_if.term m
);
    wire [1:0]  n_eff;
    wire [31:0] chars_eff;
    logic [rta_pkg::N_TERM-1:0] char_ok;

    // hdlc forces the first character to the flag and uses it alone
    assign n_eff     = m.hdlc ? 2'h0 : m.term_count;
    assign chars_eff = m.hdlc ? {m.term_chars[31:8], rta_pkg::HDLC_FLAG}
                              : m.term_chars;

    // character i is matched against the byte received n_eff-i bytes ago
    for (genvar i = 0; i < rta_pkg::N_TERM; i++) begin : g_char
        wire [1:0] sel  = n_eff - 2'(i);
        wire [7:0] rx_b = m.window[rta_pkg::BYTE_W*sel +: rta_pkg::BYTE_W];
        assign char_ok[i] = (2'(i) > n_eff) |
            rta_pkg::rta_byte_eq(rx_b,
                                 chars_eff[rta_pkg::BYTE_W*i +: rta_pkg::BYTE_W],
                                 m.term_mask[rta_pkg::BYTE_W*i +: rta_pkg::BYTE_W]);
    end

    assign m.term_hit = &char_ok;
endmodule

// >>> hw/rta_addr_match.sv
// station and group address comparator with per-bit masks
`timescale 1ns/100ps

module rta_addr_match (
    rta_match_if.addr m
);
    logic [1:0] hit;

    // k=0 group address in the low half-word, k=1 station address in the high
    for (genvar k = 0; k < 2; k++) begin : g_addr
        localparam int unsigned LSB = (k == 0) ? rta_pkg::GRP_LSB : rta_pkg::STA_LSB;
        localparam int unsigned B   = rta_pkg::BYTE_W;
        wire lo_ok = rta_pkg::rta_byte_eq(m.rx_addr[B-1:0],
                                          m.addr_regs[LSB +: B],
                                          m.addr_mask[LSB +: B]);
        wire hi_ok = rta_pkg::rta_byte_eq(m.rx_addr[2*B-1:B],
                                          m.addr_regs[LSB+B +: B],
                                          m.addr_mask[LSB+B +: B]);
        // 8-bit mode ignores the high byte
        assign hit[k] = lo_ok & (~m.wide | hi_ok);
    end

    // either comparison accepts the frame; masks give range recognition
    assign m.addr_hit = |hit;
endmodule

// >>> hw/rta_top.sv
// rx termination and address match block with apb register access
`timescale 1ns/100ps

// ============================================================================
// Summary of operation
// - termination_chars packs four byte characters, first one in lowest byte
// - term_byte_count selects how many termination characters end a frame
// - hdlc forces first termination character to 0x7E and ignores the rest
// - termination mask bit one makes that position always match
// - termination mask resets to zero; unmasked bits must equal received data
// - with address recognition, received address compared to receive_address
// - address field is taken from bytes right after the opening flag
// - unmatched address discards frame and returns to flag hunting
// - 8-bit addressing compares low byte only; 16-bit compares both bytes
// - group address also compared; either match accepts the frame
// - station address in bits 31..16, group address in bits 15..0
// - address mask bit one is don't-care; masks reset to zero
// - address mask register mirrors the address register layout
// - per-bit masks accept address ranges for broadcast recognition
// - frame start is flagged at a matching address field, or at the opening flag without address recognition
module rta_top #(
    parameter int unsigned APB_AW = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output wire logic              pready,
    output wire logic              pslverr,
    input  wire logic [7:0]        rx_byte,
    input  wire logic              rx_byte_valid,
    input  wire logic              rx_open_flag,
    input  wire logic              cfg_addr_recog,
    input  wire logic              cfg_addr_wide,
    input  wire logic              cfg_hdlc,
    input  wire logic [1:0]        term_byte_count,
    output logic      [7:0]        rx_data,
    output logic                   rx_data_valid,
    output logic                   frame_start_flag,
    output logic                   frame_end,
    output logic                   frame_reject,
    output wire logic              irq
);

    // ========================================================================
    // elaboration check
    if (APB_AW < rta_pkg::OFS_W || APB_AW > 32) begin : g_bad_aw
        $error("rta_top: APB_AW must be between 8 and 32");
    end

    // ========================================================================
    // apb decode
    wire        setup_ph;
    wire        access_ph;
    wire        wr_en;
    wire [7:0]  ofs;
    wire        sel_tc;
    wire        sel_tm;
    wire        sel_ra;
    wire        sel_rm;
    wire        sel_is;
    wire        sel_im;
    wire        sel_fs;
    wire        mapped;
    wire [31:0] rd_val;

    // decode by full byte address, so misaligned accesses are unmapped
    assign ofs       = paddr[rta_pkg::OFS_W-1:0];
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable & ce;
    assign wr_en     = access_ph & pwrite;
    assign sel_tc    = (ofs == rta_pkg::OFS_TERM_CHARS);
    assign sel_tm    = (ofs == rta_pkg::OFS_TERM_MASK);
    assign sel_ra    = (ofs == rta_pkg::OFS_RX_ADDR);
    assign sel_rm    = (ofs == rta_pkg::OFS_RX_ADDR_MASK);
    assign sel_is    = (ofs == rta_pkg::OFS_INT_STATUS);
    assign sel_im    = (ofs == rta_pkg::OFS_INT_MASK);
    assign sel_fs    = (ofs == rta_pkg::OFS_FRAME_STATUS);
    assign mapped    = sel_tc | sel_tm | sel_ra | sel_rm | sel_is | sel_im | sel_fs;
    assign pready    = ce;                       // a frozen block stalls the bus
    assign pslverr   = psel & penable & ~mapped;

    // ========================================================================
    // registers
    logic [31:0] term_chars;
    logic [31:0] term_mask;
    logic [31:0] receive_address;
    logic [31:0] receive_address_mask;
    logic [rta_pkg::IRQ_W-1:0] int_status;
    logic [rta_pkg::IRQ_W-1:0] int_mask;
    logic [rta_pkg::IRQ_W-1:0] next_int_status;
    logic [rta_pkg::IRQ_W-1:0] int_set;
    logic [rta_pkg::IRQ_W-1:0] int_clr;
    logic [15:0] last_addr;

    // termination characters and their mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_chars <= rta_pkg::TERM_CHARS_RST;
            term_mask  <= rta_pkg::TERM_MASK_RST;
        end else if (wr_en && sel_tc) begin
            term_chars <= pwdata;
        end else if (wr_en && sel_tm) begin
            term_mask <= pwdata;
        end
    end

    // station/group address and its mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_address      <= rta_pkg::RX_ADDR_RST;
            receive_address_mask <= rta_pkg::RX_ADDR_MASK_RST;
        end else if (wr_en && sel_ra) begin
            receive_address <= pwdata;
        end else if (wr_en && sel_rm) begin
            receive_address_mask <= pwdata;
        end
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= rta_pkg::INT_RST;
        end else if (wr_en && sel_im) begin
            int_mask <= pwdata[rta_pkg::IRQ_W-1:0];
        end
    end

    // sticky status, write one to clear, a new event wins over the clear
    assign int_clr         = (wr_en && sel_is) ? pwdata[rta_pkg::IRQ_W-1:0] : rta_pkg::INT_RST;
    assign next_int_status = (int_status & ~int_clr) | int_set;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= rta_pkg::INT_RST;
        end else if (ce) begin
            int_status <= next_int_status;
        end
    end
    assign irq = |(int_status & int_mask);

    // ========================================================================
    // read path, captured in the setup phase
    rta_pkg::rta_state_t state;
    rta_pkg::rta_state_t next_state;

    assign rd_val = sel_tc ? term_chars :
                    sel_tm ? term_mask :
                    sel_ra ? receive_address :
                    sel_rm ? receive_address_mask :
                    sel_is ? 32'(int_status) :
                    sel_im ? 32'(int_mask) :
                    sel_fs ? 32'({state, last_addr}) : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (ce && setup_ph) begin
            prdata <= rd_val;
        end
    end

    // ========================================================================
    // receive frame control
    wire        byte_in;
    wire        flag_in;
    wire        in_hunt;
    wire        in_hi;
    wire        in_lo;
    wire        in_data;
    wire        ev_start;
    wire        ev_end;
    wire        ev_reject;
    logic       recog_f;
    logic       wide_f;
    logic       hdlc_f;
    logic [1:0] count_f;
    logic [7:0] addr_hi;
    logic [23:0] hist;

    rta_match_if mif ();

    assign byte_in = ce & rx_byte_valid;
    assign flag_in = ce & rx_open_flag;
    assign in_hunt = (state == rta_pkg::RTA_HUNT);
    assign in_hi   = (state == rta_pkg::RTA_ADDR_HI);
    assign in_lo   = (state == rta_pkg::RTA_ADDR_LO);
    assign in_data = (state == rta_pkg::RTA_DATA);

    // comparator hookup; window holds the current byte in its low lane
    assign mif.window     = {hist, rx_byte};
    assign mif.term_chars = term_chars;
    assign mif.term_mask  = term_mask;
    assign mif.term_count = count_f;
    assign mif.hdlc       = hdlc_f;
    assign mif.rx_addr    = {wide_f ? addr_hi : 8'h00, rx_byte};
    assign mif.addr_regs  = receive_address;
    assign mif.addr_mask  = receive_address_mask;
    assign mif.wide       = wide_f;

    rta_term_match u_term (
        .m (mif.term)
    );

    rta_addr_match u_addr (
        .m (mif.addr)
    );

    // frame events
    assign ev_start  = (in_hunt & flag_in & ~cfg_addr_recog) |
                       (in_lo & byte_in & mif.addr_hit);
    assign ev_reject = in_lo & byte_in & ~mif.addr_hit;
    assign ev_end    = in_data & byte_in & mif.term_hit;
    assign int_set   = rta_pkg::IRQ_W'({ev_reject, ev_end, ev_start});

    // next state
    always_comb begin
        next_state = state;
        case (state)
            rta_pkg::RTA_HUNT: begin
                if (flag_in) begin
                    if (!cfg_addr_recog) begin
                        next_state = rta_pkg::RTA_DATA;
                    end else if (cfg_addr_wide) begin
                        next_state = rta_pkg::RTA_ADDR_HI;
                    end else begin
                        next_state = rta_pkg::RTA_ADDR_LO;
                    end
                end
            end
            rta_pkg::RTA_ADDR_HI: begin
                if (byte_in) begin
                    next_state = rta_pkg::RTA_ADDR_LO;
                end
            end
            rta_pkg::RTA_ADDR_LO: begin
                if (byte_in) begin
                    next_state = mif.addr_hit ? rta_pkg::RTA_DATA
                                              : rta_pkg::RTA_HUNT;
                end
            end
            rta_pkg::RTA_DATA: begin
                if (ev_end) begin
                    next_state = rta_pkg::RTA_HUNT;
                end
            end
            default: begin
                next_state = rta_pkg::RTA_HUNT;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= rta_pkg::RTA_HUNT;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // mode settings latched at the opening flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recog_f <= 1'b0;
            wide_f  <= 1'b0;
            hdlc_f  <= 1'b0;
            count_f <= 2'h0;
        end else if (in_hunt && flag_in) begin
            recog_f <= cfg_addr_recog;
            wide_f  <= cfg_addr_wide;
            hdlc_f  <= cfg_hdlc;
            count_f <= term_byte_count;
        end
    end

    // address capture: first byte after the flag is high in 16-bit mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_hi   <= 8'h00;
            last_addr <= 16'h0000;
        end else if (in_hi && byte_in) begin
            addr_hi <= rx_byte;
        end else if (in_lo && byte_in) begin
            last_addr <= mif.rx_addr;
        end
    end

    // history of earlier frame bytes for multi-character termination
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist <= 24'h00_0000;
        end else if (in_hunt && flag_in) begin
            hist <= 24'h00_0000;
        end else if (in_data && byte_in) begin
            hist <= mif.window[23:0];
        end
    end

    // data bytes and frame event pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data          <= 8'h00;
            rx_data_valid    <= 1'b0;
            frame_start_flag <= 1'b0;
            frame_end        <= 1'b0;
            frame_reject     <= 1'b0;
        end else if (ce) begin
            rx_data_valid    <= in_data & byte_in & ~mif.term_hit;
            frame_start_flag <= ev_start;
            frame_end        <= ev_end;
            frame_reject     <= ev_reject;
            if (in_data && byte_in && !mif.term_hit) begin
                rx_data <= rx_byte;
            end
        end
    end

    // ========================================================================
    // assertions
    property p_tc_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && sel_tc) |=> (term_chars == $past(pwdata));
    endproperty
    a_tc_write: assert property (p_tc_write) else $error("term chars write lost");

    property p_hdlc_flag_ends;
        @(posedge pclk) disable iff (!presetn)
        (in_data && byte_in && hdlc_f && rx_byte == rta_pkg::HDLC_FLAG) |=> frame_end;
    endproperty
    a_hdlc_flag_ends: assert property (p_hdlc_flag_ends) else $error("hdlc flag no end");

    property p_all_masked;
        @(posedge pclk) disable iff (!presetn)
        (in_data && byte_in && term_mask == 32'hFFFF_FFFF) |=> (frame_end && !rx_data_valid);
    endproperty
    a_all_masked: assert property (p_all_masked) else $error("masked term no end");

    property p_unmasked_miss;
        @(posedge pclk) disable iff (!presetn)
        (in_data && byte_in && !hdlc_f && count_f == 2'h0 && term_mask == 32'h0000_0000
         && rx_byte != term_chars[7:0]) |=> (!frame_end && rx_data_valid);
    endproperty
    a_unmasked_miss: assert property (p_unmasked_miss) else $error("false termination");

    property p_reject_hunt;
        @(posedge pclk) disable iff (!presetn)
        frame_reject |-> (in_hunt && !frame_start_flag);
    endproperty
    a_reject_hunt: assert property (p_reject_hunt) else $error("reject not hunting");

    property p_match_start;
        @(posedge pclk) disable iff (!presetn)
        (in_lo && byte_in && mif.addr_hit) |=> (frame_start_flag && in_data)
                                            ##1 (!ce || int_status[rta_pkg::IRQ_START]);
    endproperty
    a_match_start: assert property (p_match_start) else $error("no frame start");

    property p_wide_only_hi;
        @(posedge pclk) disable iff (!presetn)
        in_hi |-> (wide_f && recog_f);
    endproperty
    a_wide_only_hi: assert property (p_wide_only_hi) else $error("high byte in 8-bit");

    property p_cfg_static;
        @(posedge pclk) disable iff (!presetn)
        (!in_hunt && !$past(in_hunt)) |-> ($stable(wide_f) && $stable(hdlc_f));
    endproperty
    a_cfg_static: assert property (p_cfg_static) else $error("mode changed in frame");

    property p_open_flag;
        @(posedge pclk) disable iff (!presetn)
        (in_hunt && flag_in && cfg_addr_recog) |=> (in_hi || in_lo);
    endproperty
    a_open_flag: assert property (p_open_flag) else $error("address phase skipped");

    c_start:  cover property (@(posedge pclk) disable iff (!presetn) frame_start_flag);
    c_end:    cover property (@(posedge pclk) disable iff (!presetn) frame_end);
    c_reject: cover property (@(posedge pclk) disable iff (!presetn) frame_reject);
    c_wide:   cover property (@(posedge pclk) disable iff (!presetn)
                              in_hi ##1 (in_lo && byte_in && mif.addr_hit));

endmodule

// >>> testbench/rta_remote_station.sv
// remote station model: opening flags and received bytes
`timescale 1ns/100ps
module rta_remote_station (
    input  wire logic pclk,
    output logic [7:0] rx_byte,
    output logic       rx_byte_valid,
    output logic       rx_open_flag
);
    initial begin
        rx_byte       = 8'h00;
        rx_byte_valid = 1'b0;
        rx_open_flag  = 1'b0;
    end
    // flag pulse, then an idle cycle; address bytes follow it
    task automatic send_flag();
        rx_open_flag <= 1'b1;
        @(posedge pclk);
        rx_open_flag <= 1'b0;
        @(posedge pclk);
    endtask
    // byte pulse; idle line shows the inverse, never a stale copy
    task automatic send_byte(input logic [7:0] b);
        rx_byte       <= b;
        rx_byte_valid <= 1'b1;
        @(posedge pclk);
        rx_byte       <= ~b;
        rx_byte_valid <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// >>> testbench/test_rx_term_and_address_match.sv
// self-checking bench for the termination and address matcher
`timescale 1ns/100ps
module test_rx_term_and_address_match;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err, ce;
    logic        cfg_recog, cfg_wide, cfg_hdlc, irq, frame_start_flag, frame_end;
    logic        frame_reject, rx_data_valid, rx_byte_valid, rx_open_flag;
    logic [1:0]  tcount;
    logic [7:0]  paddr, rx_byte, rx_data;
    logic [31:0] pwdata, prdata, rd;
    int          err_count, checks, cyc, n_start, n_end, n_rej, n_data;
    rta_top rta_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid), .rx_open_flag(rx_open_flag),
        .cfg_addr_recog(cfg_recog), .cfg_addr_wide(cfg_wide), .cfg_hdlc(cfg_hdlc),
        .term_byte_count(tcount), .rx_data(rx_data), .rx_data_valid(rx_data_valid),
        .frame_start_flag(frame_start_flag), .frame_end(frame_end),
        .frame_reject(frame_reject), .irq(irq));
    rta_remote_station rta_remote_station_i (.pclk(pclk), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid), .rx_open_flag(rx_open_flag));
    // ========================================================================
    // clock, pulse counters and hang limit
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        n_start <= n_start + int'(frame_start_flag === 1'b1);
        n_end <= n_end + int'(frame_end === 1'b1);
        n_rej <= n_rej + int'(frame_reject === 1'b1);
        n_data <= n_data + int'(rx_data_valid === 1'b1);
        if (cyc == 20000) begin
            err_count = err_count + 1;
            tally_and_finish();
        end
    end
    // ========================================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // idle edge between transfers
    endtask
    task automatic term_case(input logic [1:0] c, input logic h, input logic [31:0] m,
                             input logic [31:0] seq, input int n);
        int e;
        int d;
        tcount <= c;
        cfg_hdlc <= h;
        apb(1'b1, rta_pkg::OFS_TERM_MASK, m);
        e = n_end;
        d = n_data;
        rta_remote_station_i.send_flag();
        for (int k = 0; k < n; k++) begin
            rta_remote_station_i.send_byte(seq[8*k+:8]);
        end
        @(posedge pclk);
        check(32'(n_end - e), 32'h0000_0001);
        check(32'(n_data - d), 32'(n - 1));
        check(32'(rx_data), 32'(seq[8*(n-2)+:8]));
    endtask
    // flag, address, one payload byte, then terminator 0xEE
    task automatic addr_case(input logic w, input logic [7:0] hi, lo, input logic acc);
        int s;
        int r;
        int d;
        s = n_start;
        r = n_rej;
        d = n_data;
        cfg_wide <= w;
        rta_remote_station_i.send_flag();
        if (w) begin
            rta_remote_station_i.send_byte(hi);
        end
        rta_remote_station_i.send_byte(lo);
        rta_remote_station_i.send_byte(8'hA5);
        rta_remote_station_i.send_byte(8'hEE);
        @(posedge pclk);
        check(32'(n_start - s), {31'b0, acc});
        check(32'(n_rej - r), {31'b0, !acc});
        check(32'(n_data - d), {31'b0, acc});
        if (acc) begin
            check(32'(rx_data), 32'h0000_00A5);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ========================================================================
    // main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, cfg_recog, cfg_wide, cfg_hdlc} = '0;
        {tcount, paddr, pwdata, err_count, checks, cyc} = '0;
        {n_start, n_end, n_rej, n_data} = '0;
        ce = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // register reset values, readback, unmapped place
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'h34 + 8'(4 * i), 32'h0);
            check(rd, 32'h0000_0000);
            apb(1'b1, 8'h34 + 8'(4 * i), 32'h5A3C_0F11 + 32'(i));
            apb(1'b0, 8'h34 + 8'(4 * i), 32'h0);
            check(rd, 32'h5A3C_0F11 + 32'(i));
        end
        apb(1'b0, 8'h50, 32'h0);
        check({rd[30:0], last_err}, 32'h0000_0001);
        // termination: two and four character counts, mask, hdlc forcing
        apb(1'b1, rta_pkg::OFS_TERM_CHARS, 32'h4433_2211);
        term_case(2'd1, 1'b0, 32'h0, 32'h0022_1122, 3);
        term_case(2'd3, 1'b0, 32'h0, 32'h4433_2211, 4);
        term_case(2'd0, 1'b0, 32'h0000_000F, 32'h0000_1F51, 2);
        term_case(2'd3, 1'b1, 32'h0, 32'h0000_7E11, 2);
        // address recognition, station and group, both widths, masks
        cfg_hdlc <= 1'b0;
        cfg_recog <= 1'b1;
        tcount <= 2'd0;
        apb(1'b1, rta_pkg::OFS_TERM_CHARS, 32'h0000_00EE);
        apb(1'b1, rta_pkg::OFS_RX_ADDR, 32'h125A_34C3);
        apb(1'b1, rta_pkg::OFS_RX_ADDR_MASK, 32'h0);
        apb(1'b1, rta_pkg::OFS_INT_MASK, 32'h0000_0004);
        addr_case(1'b0, 8'h00, 8'h5A, 1'b1);
        addr_case(1'b0, 8'h00, 8'hC3, 1'b1);
        check(irq, 1'b0);
        addr_case(1'b0, 8'h00, 8'h77, 1'b0);
        check(irq, 1'b1);
        apb(1'b1, rta_pkg::OFS_INT_STATUS, 32'h0000_0004);
        check(irq, 1'b0);
        addr_case(1'b1, 8'h12, 8'h5A, 1'b1);
        addr_case(1'b1, 8'h13, 8'h5A, 1'b0);
        addr_case(1'b1, 8'h34, 8'hC3, 1'b1);
        addr_case(1'b1, 8'h12, 8'hC3, 1'b0);
        // a flag seen while frozen must not open a frame
        ce <= 1'b0;
        rta_remote_station_i.send_flag();
        ce <= 1'b1;
        apb(1'b0, rta_pkg::OFS_FRAME_STATUS, 32'h0);
        check(rd, 32'h0001_12C3);
        apb(1'b1, rta_pkg::OFS_RX_ADDR_MASK, 32'h000F_0000);
        addr_case(1'b0, 8'h00, 8'h57, 1'b1);
        addr_case(1'b0, 8'h00, 8'h67, 1'b0);
        tally_and_finish();
    end
endmodule
